// [rtl/spc_port_ctrl.sv]
// Per-port control registers of a three-port switch and the values they steer.
// Assumes one clock, a plain register port with read data one cycle later,
// and lookup/egress requests arriving synchronous to the clock.
`timescale 1ns/100ps
`include "spc_port_regs.svh"
`default_nettype none

module spc_port_ctrl
  import spc_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst_b,
  input  wire logic              ce,
  input  wire logic [9:0]        addr,
  input  wire logic [7:0]        wr_data,
  input  wire logic              wr_strb,
  input  wire logic              rd_strb,
  output logic      [7:0]        rd_data,
  input  wire logic              port3_rx_valid_strap_pin,
  input  wire logic              lkp_valid,
  input  wire logic [1:0]        lkp_port,
  input  wire logic              lkp_tagged,
  input  wire logic [11:0]       lkp_vid,
  input  wire logic              lkp_bcast,
  input  wire logic              lkp_mcast,
  input  wire logic              lkp_flood,
  output logic                   lkp_done,
  output logic      [11:0]       lkp_vid_out,
  output logic                   lkp_accept,
  output logic                   lkp_learn,
  output logic                   lkp_counted,
  input  wire logic              eg_valid,
  input  wire logic [1:0]        eg_port,
  output logic                   eg_done,
  output logic      [15:0]       eg_tag,
  output logic      [2:0]        rx_enable,
  output logic      [2:0]        learn_disable,
  output logic      [2:0][15:0]  default_tag,
  output logic      [2:0]        sa_filter_first_en,
  output logic      [2:0]        sa_filter_second_en,
  output logic      [2:0]        drop_tagged,
  output logic      [2:0][1:0]   limit_mode,
  output logic                   port3_mac_mode,
  output logic                   port1_phy_clk_off
);

  // ----------------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------------
  function automatic logic spc_hit(input logic [9:0] a, input spc_port_t pnum, input logic [3:0] kind);
    return (a[9:8] == 2'h0) && (a[7:6] == pnum) && (a[5:2] == kind) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic spc_counts(input spc_limit_e mode, input logic bc, input logic mc, input logic fl);
    logic r;
    r = 1'b0;
    case (mode)
      SPC_LIM_ALL:         r = 1'b1;
      SPC_LIM_BC_MC_FLOOD: r = bc | mc | fl;
      SPC_LIM_BC_MC:       r = bc | mc;
      SPC_LIM_BC:          r = bc;
      default:             r = 1'b0;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------------
  logic      rx_en_q     [3];
  logic      learn_dis_q [3];
  spc_byte_t tagh_q      [3];
  spc_byte_t tagl_q      [3];
  spc_byte_t mode_q      [3];
  logic      strap_done_q;
  spc_byte_t rd_mux;

  // Strap is caught on the first enabled edge after reset release
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      strap_done_q <= 1'b0;
    else if (ce)
      strap_done_q <= 1'b1;
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_port
      localparam spc_port_t PNUM = spc_port_t'(g + 1);
      localparam spc_byte_t WMASK = (g == 2) ? `SPC_MODE3_WMASK : `SPC_MODE_WMASK;

      always_ff @(posedge clock or negedge rst_b)
      begin
        if (!rst_b)
        begin
          rx_en_q[g]     <= `SPC_RX_EN_RST;
          learn_dis_q[g] <= `SPC_LEARN_DIS_RST;
        end
        else if (ce && wr_strb && spc_hit(addr, PNUM, `SPC_KIND_RXLEARN))
        begin
          rx_en_q[g]     <= wr_data[`SPC_RX_EN_BIT];
          learn_dis_q[g] <= wr_data[`SPC_LEARN_DIS_BIT];
        end
      end

      always_ff @(posedge clock or negedge rst_b)
      begin
        if (!rst_b)
        begin
          tagh_q[g] <= `SPC_TAGH_RST;
          tagl_q[g] <= `SPC_TAGL_RST;
        end
        else if (ce && wr_strb)
        begin
          if (spc_hit(addr, PNUM, `SPC_KIND_TAGH))
            tagh_q[g] <= wr_data;
          if (spc_hit(addr, PNUM, `SPC_KIND_TAGL))
            tagl_q[g] <= wr_data;
        end
      end

      // Port 3 drops bits 6 and 5, so they read zero; a write beside the strap capture wins
      always_ff @(posedge clock or negedge rst_b)
      begin
        if (!rst_b)
          mode_q[g] <= `SPC_MODE_RST;
        else if (ce && wr_strb && spc_hit(addr, PNUM, `SPC_KIND_MODE))
          mode_q[g] <= wr_data & WMASK;
        else if ((g == 2) && ce && !strap_done_q)
          mode_q[g][`SPC_MODE_SEL_BIT] <= ~port3_rx_valid_strap_pin;
      end

      assign rx_enable[g]           = rx_en_q[g];
      assign learn_disable[g]       = learn_dis_q[g];
      assign default_tag[g]         = {tagh_q[g], tagl_q[g]};
      assign sa_filter_first_en[g]  = mode_q[g][`SPC_FILT1_BIT];
      assign sa_filter_second_en[g] = mode_q[g][`SPC_FILT2_BIT];
      assign drop_tagged[g]         = mode_q[g][`SPC_DROP_TAG_BIT];
      assign limit_mode[g]          = mode_q[g][`SPC_LIMIT_HI:`SPC_LIMIT_LO];

      // ----------------------------------------------------------------------------
      // Per-port checks
      // ----------------------------------------------------------------------------
      sequence s_rxl_wr;
        ce && wr_strb && spc_hit(addr, PNUM, `SPC_KIND_RXLEARN);
      endsequence

      property p_rx_en;
        @(posedge clock) disable iff (!rst_b)
        s_rxl_wr |=> (rx_enable[g] == $past(wr_data[`SPC_RX_EN_BIT]));
      endproperty
      a_rx_en: assert property (p_rx_en) else $error("receive enable not taken from write");

      property p_learn;
        @(posedge clock) disable iff (!rst_b)
        s_rxl_wr ##1 (ce && lkp_valid && lkp_port == spc_port_t'(g) && rx_enable[g] && !lkp_tagged)
          |=> (lkp_learn == !$past(wr_data[`SPC_LEARN_DIS_BIT], 2));
      endproperty
      a_learn: assert property (p_learn) else $error("learning does not follow learn disable");

      sequence s_tagh_wr;
        ce && wr_strb && spc_hit(addr, PNUM, `SPC_KIND_TAGH);
      endsequence
      sequence s_tagh_rd;
        ce && rd_strb && spc_hit(addr, PNUM, `SPC_KIND_TAGH);
      endsequence

      property p_tagh_rb;
        @(posedge clock) disable iff (!rst_b)
        s_tagh_wr ##1 s_tagh_rd |=> (rd_data == $past(wr_data, 2));
      endproperty
      a_tagh_rb: assert property (p_tagh_rb) else $error("tag high byte readback wrong");

      property p_eg_tag;
        @(posedge clock) disable iff (!rst_b)
        (ce && eg_valid && eg_port == spc_port_t'(g))
          |=> eg_done && (eg_tag[15:8] == $past(tagh_q[g])) && (eg_tag[7:0] == $past(tagl_q[g]));
      endproperty
      a_eg_tag: assert property (p_eg_tag) else $error("egress tag is not the port default tag");
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------------------
  always_comb
  begin
    rd_mux = 8'h00;
    for (int p = 0; p < 3; p++)
    begin
      if (spc_hit(addr, spc_port_t'(p + 1), `SPC_KIND_RXLEARN))
        rd_mux = {6'h00, rx_en_q[p], learn_dis_q[p]};
      if (spc_hit(addr, spc_port_t'(p + 1), `SPC_KIND_TAGH))
        rd_mux = tagh_q[p];
      if (spc_hit(addr, spc_port_t'(p + 1), `SPC_KIND_TAGL))
        rd_mux = tagl_q[p];
      if (spc_hit(addr, spc_port_t'(p + 1), `SPC_KIND_MODE))
        rd_mux = mode_q[p];
    end
  end

  // Data stands only in the cycle after the strobe; unmapped addresses read zero
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      rd_data <= 8'h00;
    else if (ce)
      rd_data <= rd_strb ? rd_mux : 8'h00;
  end

  assign port3_mac_mode    = mode_q[2][`SPC_MODE_SEL_BIT];
  assign port1_phy_clk_off = mode_q[0][`SPC_MODE_SEL_BIT];

  // ----------------------------------------------------------------------------
  // Ingress lookup
  // ----------------------------------------------------------------------------
  // Port code 3 names no port: answered, but refused with VID zero
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lkp_done    <= 1'b0;
      lkp_vid_out <= 12'h000;
      lkp_accept  <= 1'b0;
      lkp_learn   <= 1'b0;
      lkp_counted <= 1'b0;
    end
    else if (ce)
    begin
      lkp_done    <= lkp_valid;
      lkp_vid_out <= 12'h000;
      lkp_accept  <= 1'b0;
      lkp_learn   <= 1'b0;
      lkp_counted <= 1'b0;
      if (lkp_valid && lkp_port != 2'h3)
      begin
        if (lkp_tagged && lkp_vid != 12'h000)
          lkp_vid_out <= lkp_vid;
        else
          lkp_vid_out <= {tagh_q[lkp_port][3:0], tagl_q[lkp_port]};
        lkp_accept  <= rx_en_q[lkp_port] && !(lkp_tagged && mode_q[lkp_port][`SPC_DROP_TAG_BIT]);
        lkp_learn   <= rx_en_q[lkp_port] && !(lkp_tagged && mode_q[lkp_port][`SPC_DROP_TAG_BIT])
                       && !learn_dis_q[lkp_port];
        lkp_counted <= spc_counts(spc_limit_e'(mode_q[lkp_port][`SPC_LIMIT_HI:`SPC_LIMIT_LO]),
                                  lkp_bcast, lkp_mcast, lkp_flood);
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Egress tag insertion
  // ----------------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      eg_done <= 1'b0;
      eg_tag  <= 16'h0000;
    end
    else if (ce)
    begin
      eg_done <= eg_valid;
      if (eg_valid && eg_port != 2'h3)
        eg_tag <= {tagh_q[eg_port], tagl_q[eg_port]};
      else
        eg_tag <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  sequence s_untagged_p0;
    ce && lkp_valid && lkp_port == 2'h0 && (!lkp_tagged || lkp_vid == 12'h000);
  endsequence

  property p_lkp_vid;
    @(posedge clock) disable iff (!rst_b)
    s_untagged_p0 |=> lkp_done && (lkp_vid_out == {$past(tagh_q[0][3:0]), $past(tagl_q[0])});
  endproperty
  a_lkp_vid: assert property (p_lkp_vid) else $error("untagged frame did not get default VID");

  property p_strap;
    @(posedge clock) disable iff (!rst_b)
    (rst_b && ce && !strap_done_q && !(wr_strb && spc_hit(addr, 2'h3, `SPC_KIND_MODE)))
      |=> (port3_mac_mode == !$past(port3_rx_valid_strap_pin));
  endproperty
  a_strap: assert property (p_strap) else $error("port 3 role not inverse of strap");

  property p_mode_sel;
    @(posedge clock) disable iff (!rst_b)
    (ce && wr_strb && spc_hit(addr, 2'h3, `SPC_KIND_MODE)) ##1 (!(ce && wr_strb))[*2]
      |-> (port3_mac_mode == $past(wr_data[`SPC_MODE_SEL_BIT], 2));
  endproperty
  a_mode_sel: assert property (p_mode_sel) else $error("port 3 role bit lost its write");

  property p_clk_off;
    @(posedge clock) disable iff (!rst_b)
    (ce && wr_strb && spc_hit(addr, 2'h1, `SPC_KIND_MODE)) |=> (port1_phy_clk_off == $past(wr_data[7]));
  endproperty
  a_clk_off: assert property (p_clk_off) else $error("port 1 clock shut-off bit not written");

  property p_filt1;
    @(posedge clock) disable iff (!rst_b)
    (ce && wr_strb && spc_hit(addr, 2'h1, `SPC_KIND_MODE)) |=> (sa_filter_first_en[0] == $past(wr_data[6]));
  endproperty
  a_filt1: assert property (p_filt1) else $error("port 1 self-address filter enable wrong");

  property p_p3_no_filt;
    @(posedge clock) disable iff (!rst_b)
    (ce && rd_strb && spc_hit(addr, 2'h3, `SPC_KIND_MODE)) |=> (rd_data[6:5] == 2'h0) && !sa_filter_second_en[2];
  endproperty
  a_p3_no_filt: assert property (p_p3_no_filt) else $error("port 3 filter bits not zero");

  property p_drop;
    @(posedge clock) disable iff (!rst_b)
    (ce && lkp_valid && lkp_tagged && lkp_port != 2'h3 && drop_tagged[lkp_port]) |=> !lkp_accept && !lkp_learn;
  endproperty
  a_drop: assert property (p_drop) else $error("tagged frame accepted while dropping tagged");

  property p_limit_bc;
    @(posedge clock) disable iff (!rst_b)
    (ce && lkp_valid && lkp_port == 2'h0 && limit_mode[0] == 2'h3 && !lkp_bcast) |=> lkp_done && !lkp_counted;
  endproperty
  a_limit_bc: assert property (p_limit_bc) else $error("non-broadcast counted in broadcast-only mode");

  property p_tag_join;
    @(posedge clock) disable iff (!rst_b)
    (ce && eg_valid && eg_port == 2'h2) |=> (eg_tag == $past(default_tag[2]))
      && (eg_tag[`SPC_PCP_HI:`SPC_PCP_LO] == $past(tagh_q[2][7:5]));
  endproperty
  a_tag_join: assert property (p_tag_join) else $error("joined tag has bytes out of place");

  property p_tagl_rst;
    @(posedge clock) disable iff (!rst_b)
    (ce && rd_strb && spc_hit(addr, 2'h1, `SPC_KIND_TAGL) && !$past(wr_strb)) ##0 (tagl_q[0] == `SPC_TAGL_RST)
      |=> (rd_data == `SPC_TAGL_RST);
  endproperty
  a_tagl_rst: assert property (p_tagl_rst) else $error("tag low byte readback wrong");

endmodule

`default_nettype wire

// [include/spc_port_regs.svh]
// Register indices, field positions, reset values and masks of the per-port control bank.
// Assumes byte address = 4 * index, index = {port number, register kind}.
`ifndef SPC_PORT_REGS_SVH
`define SPC_PORT_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------------
`define SPC_OFS_P1_RXLEARN 8'h12
`define SPC_OFS_P1_TAGH    8'h13
`define SPC_OFS_P1_TAGL    8'h14
`define SPC_OFS_P1_MODE    8'h15
`define SPC_OFS_P2_RXLEARN 8'h22
`define SPC_OFS_P2_TAGH    8'h23
`define SPC_OFS_P2_TAGL    8'h24
`define SPC_OFS_P2_MODE    8'h25
`define SPC_OFS_P3_RXLEARN 8'h32
`define SPC_OFS_P3_TAGH    8'h33
`define SPC_OFS_P3_TAGL    8'h34
`define SPC_OFS_P3_MODE    8'h35

// Register kind is the low nibble of the index, port number the next two bits
`define SPC_KIND_RXLEARN   4'h2
`define SPC_KIND_TAGH      4'h3
`define SPC_KIND_TAGL      4'h4
`define SPC_KIND_MODE      4'h5

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define SPC_RX_EN_BIT      1
`define SPC_LEARN_DIS_BIT  0
`define SPC_RX_EN_RST      1'b1
`define SPC_LEARN_DIS_RST  1'b0
`define SPC_TAGH_RST       8'h00
`define SPC_TAGL_RST       8'h01
`define SPC_MODE_RST       8'h00
`define SPC_MODE_SEL_BIT   7
`define SPC_FILT1_BIT      6
`define SPC_FILT2_BIT      5
`define SPC_DROP_TAG_BIT   4
`define SPC_LIMIT_HI       3
`define SPC_LIMIT_LO       2
`define SPC_MODE_WMASK     8'hFC
`define SPC_MODE3_WMASK    8'h9C
`define SPC_PCP_HI         15
`define SPC_PCP_LO         13
`define SPC_CFI_BIT        12
`define SPC_VID_HI         11

`endif

// [include/spc_pkg.sv]
// Types shared by the per-port control bank.
// Assumes spc_port_regs.svh for all numeric constants.
package spc_pkg;

  typedef logic [1:0] spc_port_t;
  typedef logic [7:0] spc_byte_t;
  typedef logic [11:0] spc_vid_t;
  typedef logic [15:0] spc_tag_t;

  // Ingress limit mode, in field order
  typedef enum logic [1:0] {
    SPC_LIM_ALL,
    SPC_LIM_BC_MC_FLOOD,
    SPC_LIM_BC_MC,
    SPC_LIM_BC
  } spc_limit_e;

endpackage

// [sim/spc_port_ctrl_tb.sv]
// Self-checking bench of the per-port control bank: reset values, tags, lookup, egress, mode bits.
// Assumes spc_port_ctrl with byte address = 4 * register index and one-cycle read data.
`timescale 1ns/100ps
`default_nettype none

module spc_port_ctrl_tb
  import spc_pkg::*;
  ;
  logic             clock;
  logic             rst_b;
  logic             ce;
  logic [9:0]       addr;
  logic [7:0]       wr_data;
  logic             wr_strb;
  logic             rd_strb;
  logic [7:0]       rd_data;
  logic             strap;
  logic             lkp_valid;
  logic [1:0]       lkp_port;
  logic             lkp_tagged;
  logic [11:0]      lkp_vid;
  logic             lkp_bcast;
  logic             lkp_mcast;
  logic             lkp_flood;
  logic             lkp_done;
  logic [11:0]      lkp_vid_out;
  logic             lkp_accept;
  logic             lkp_learn;
  logic             lkp_counted;
  logic             eg_valid;
  logic [1:0]       eg_port;
  logic             eg_done;
  logic [15:0]      eg_tag;
  logic [2:0]       rx_enable;
  logic [2:0]       learn_disable;
  logic [2:0][15:0] default_tag;
  logic [2:0]       sa_first;
  logic [2:0]       sa_second;
  logic [2:0]       drop_tagged;
  logic [2:0][1:0]  limit_mode;
  logic             port3_mac_mode;
  logic             port1_phy_clk_off;
  int               fail_count;
  int               num_checks;

  spc_port_ctrl u_spc_port_ctrl (
    .clock(clock), .rst_b(rst_b), .ce(ce), .addr(addr), .wr_data(wr_data), .wr_strb(wr_strb),
    .rd_strb(rd_strb), .rd_data(rd_data), .port3_rx_valid_strap_pin(strap),
    .lkp_valid(lkp_valid), .lkp_port(lkp_port), .lkp_tagged(lkp_tagged), .lkp_vid(lkp_vid),
    .lkp_bcast(lkp_bcast), .lkp_mcast(lkp_mcast), .lkp_flood(lkp_flood), .lkp_done(lkp_done),
    .lkp_vid_out(lkp_vid_out), .lkp_accept(lkp_accept), .lkp_learn(lkp_learn),
    .lkp_counted(lkp_counted), .eg_valid(eg_valid), .eg_port(eg_port), .eg_done(eg_done),
    .eg_tag(eg_tag), .rx_enable(rx_enable), .learn_disable(learn_disable),
    .default_tag(default_tag), .sa_filter_first_en(sa_first), .sa_filter_second_en(sa_second),
    .drop_tagged(drop_tagged), .limit_mode(limit_mode), .port3_mac_mode(port3_mac_mode),
    .port1_phy_clk_off(port1_phy_clk_off)
  );

  always #12.5 clock = ~clock;

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string nm, input logic [16:0] seen, input logic [16:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Returns just after the taking edge, so config outputs have settled
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge clock);
    addr    <= {idx, 2'b00};
    wr_data <= d;
    wr_strb <= 1'b1;
    @(posedge clock);
    wr_strb <= 1'b0;
    #1;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    @(posedge clock);
    addr    <= {idx, 2'b00};
    rd_strb <= 1'b1;
    @(posedge clock);
    rd_strb <= 1'b0;
    #1;
    chk($sformatf("reg %h", idx), 17'(rd_data), 17'(exp));
  endtask

  // Result packed as {done, accept, learn, counted, vid}
  task automatic lk(input logic [1:0] p, input logic tg, input logic [11:0] v, input logic [2:0] cls,
                    output logic [15:0] r);
    @(posedge clock);
    lkp_valid  <= 1'b1;
    lkp_port   <= p;
    lkp_tagged <= tg;
    lkp_vid    <= v;
    {lkp_bcast, lkp_mcast, lkp_flood} <= cls;
    @(posedge clock);
    lkp_valid <= 1'b0;
    #1;
    r = {lkp_done, lkp_accept, lkp_learn, lkp_counted, lkp_vid_out};
  endtask

  task automatic egchk(input logic [1:0] p, input logic [15:0] exp);
    @(posedge clock);
    eg_valid <= 1'b1;
    eg_port  <= p;
    @(posedge clock);
    eg_valid <= 1'b0;
    #1;
    chk("egress", {eg_done, eg_tag}, {1'b1, exp});
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] b;
    repeat (3) @(posedge clock);
    #1;
    chk("rx_en in reset", 17'(rx_enable), 17'h7);
    @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    #1;
    chk("mac mode strap", 17'(port3_mac_mode), 17'h1);
    for (int p = 1; p <= 3; p++)
    begin
      b = 8'(p << 4);
      rdchk(b | 8'h02, 8'h02);
      rdchk(b | 8'h03, 8'h00);
      rdchk(b | 8'h04, 8'h01);
      rdchk(b | 8'h05, (p == 3) ? 8'h80 : 8'h00);
      chk("tag rst", 17'(default_tag[p-1]), 17'h0001);
    end
    chk("learn rst", 17'(learn_disable), 17'h0);
    chk("limit rst", 17'(limit_mode), 17'h0);
    rdchk(8'h16, 8'h00);
  endtask

  task automatic t_tags();
    logic [7:0] b;
    logic [7:0] hi;
    logic [7:0] lo;
    for (int p = 1; p <= 3; p++)
    begin
      b  = 8'(p << 4);
      hi = 8'hB0 | 8'(p);
      lo = 8'h30 + 8'(p);
      wr(b | 8'h03, hi);
      wr(b | 8'h04, lo);
      chk("tag join", 17'(default_tag[p-1]), 17'({hi, lo}));
      rdchk(b | 8'h03, hi);
      rdchk(b | 8'h04, lo);
      egchk(2'(p - 1), {hi, lo});
    end
    egchk(2'h3, 16'h0000);
  endtask

  task automatic t_lookup();
    logic [15:0] r;
    logic [2:0]  cls;
    logic        cnt;
    lk(2'h0, 1'b0, 12'h7FF, 3'h0, r);
    chk("untagged", 17'(r), 17'hF131);
    lk(2'h0, 1'b1, 12'h000, 3'h0, r);
    chk("null vid", 17'(r), 17'hF131);
    lk(2'h0, 1'b1, 12'h123, 3'h0, r);
    chk("tagged vid", 17'(r), 17'hF123);
    wr(8'h12, 8'h03);
    chk("learn out", 17'(learn_disable), 17'h1);
    lk(2'h0, 1'b0, 12'h000, 3'h0, r);
    chk("no learn", 17'(r[15:13]), 17'h6);
    wr(8'h22, 8'h00);
    chk("rx out", 17'(rx_enable), 17'h5);
    lk(2'h1, 1'b0, 12'h000, 3'h0, r);
    chk("rx off", 17'(r[15:13]), 17'h4);
    wr(8'h35, 8'h90);
    lk(2'h2, 1'b1, 12'h005, 3'h0, r);
    chk("drop tagged", 17'(r[15:14]), 17'h2);
    lk(2'h2, 1'b0, 12'h000, 3'h0, r);
    chk("pass untagged", 17'(r[15:14]), 17'h3);
    // Counting ignores receive enable, so only the limit mode and the class decide it
    for (int m = 0; m < 4; m++)
    begin
      wr(8'h15, 8'(m << 2));
      chk("limit out", 17'(limit_mode[0]), 17'(m));
      for (int k = 0; k < 4; k++)
      begin
        cls = (k == 0) ? 3'h0 : 3'(1 << (k - 1));
        cnt = (m == 0) || (m == 1 && cls != 3'h0) || (m == 2 && cls[2:1] != 2'h0) || (m == 3 && cls[2]);
        lk(2'h0, 1'b0, 12'h000, cls, r);
        chk($sformatf("count m%0d k%0d", m, k), 17'(r[12]), 17'(cnt));
      end
    end
  endtask

  task automatic t_mode();
    wr(8'h15, 8'hFF);
    rdchk(8'h15, 8'hFC);
    chk("clk off", 17'(port1_phy_clk_off), 17'h1);
    chk("filt1 p1", 17'(sa_first[0]), 17'h1);
    chk("drop p1", 17'(drop_tagged[0]), 17'h1);
    wr(8'h25, 8'h20);
    chk("filt2 p2", 17'(sa_second[1]), 17'h1);
    wr(8'h35, 8'hFF);
    rdchk(8'h35, 8'h9C);
    chk("p3 filters", 17'({sa_first[2], sa_second[2]}), 17'h0);
    chk("mac role", 17'(port3_mac_mode), 17'h1);
    wr(8'h35, 8'h7F);
    chk("phy role", 17'(port3_mac_mode), 17'h0);
    wr(8'h15, 8'h00);
    chk("clk on", 17'(port1_phy_clk_off), 17'h0);
    chk("filt1 off", 17'(sa_first[0]), 17'h0);
    wr(8'h16, 8'hFF);
    rdchk(8'h16, 8'h00);
    rdchk(8'h15, 8'h00);
  endtask

  // Back-to-back strobes, a lookup right after a write, then a write while frozen
  task automatic t_b2b_freeze();
    @(posedge clock);
    addr    <= {8'h12, 2'b00};
    wr_data <= 8'h02;
    wr_strb <= 1'b1;
    @(posedge clock);
    addr       <= {8'h13, 2'b00};
    wr_data    <= 8'h5A;
    lkp_valid  <= 1'b1;
    lkp_port   <= 2'h0;
    lkp_tagged <= 1'b0;
    @(posedge clock);
    wr_strb   <= 1'b0;
    rd_strb   <= 1'b1;
    lkp_valid <= 1'b0;
    #1;
    chk("learn after b2b write", 17'(lkp_learn), 17'h1);
    @(posedge clock);
    rd_strb <= 1'b0;
    #1;
    chk("b2b readback", 17'(rd_data), 17'h05A);
    @(posedge clock);
    ce <= 1'b0;
    wr(8'h14, 8'hAA);
    @(posedge clock);
    ce <= 1'b1;
    rdchk(8'h14, 8'h31);
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    rst_b = 1'b0;
    ce = 1'b1;
    addr = 10'h000;
    wr_data = 8'h00;
    wr_strb = 1'b0;
    rd_strb = 1'b0;
    strap = 1'b0;
    lkp_valid = 1'b0;
    lkp_port = 2'h0;
    lkp_tagged = 1'b0;
    lkp_vid = 12'h000;
    {lkp_bcast, lkp_mcast, lkp_flood} = 3'h0;
    eg_valid = 1'b0;
    eg_port = 2'h0;
    fail_count = 0;
    num_checks = 0;
    t_reset();
    t_tags();
    t_lookup();
    t_mode();
    t_b2b_freeze();
    tally_and_finish();
  end

  // Cuts a hang short; counts as a mismatch
  initial
  begin
    #(25 * 20000);
    fail_count++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
